/* core/updsi_pkg.sv */
package updsi_pkg;
    // clock and line timing
    localparam int CLK_HZ = 125_000_000;
    localparam int BAUD_DEFAULT = 115_200;
    localparam int OVERSAMPLE = 16;
    localparam int TICK_DIV_DEFAULT = CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE);
    localparam logic [3:0] PHASE_LAST = 4'hF;
    localparam logic [3:0] PHASE_MID = 4'h8;
    localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
    localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
    localparam logic [3:0] STOP_BIT_INDEX = 4'h9;

    // data path sizes
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int BURST_LEVEL = 4;

    // reset and idle levels of the pad outputs
    localparam logic TXD_RESET = 1'b1;
    localparam logic IR_OUT_IDLE = 1'b0;
    localparam logic MODEM_OUT_RESET = 1'b0;

    // dma request lines toward the controller, active high
    typedef struct packed {
        logic txDmaSingleRequest;
        logic txDmaBurstRequest;
        logic rxDmaSingleRequest;
        logic rxDmaBurstRequest;
    } updsi_dma_req_t;

    // modem status pads, active low as they arrive
    typedef struct packed {
        logic clearToSendInN;
        logic carrierDetectInN;
        logic setReadyInN;
        logic ringIndicatorInN;
    } updsi_modem_in_t;

    // modem status as seen by software, active high
    typedef struct packed {
        logic clearToSend;
        logic carrierDetect;
        logic setReady;
        logic ringIndicator;
    } updsi_modem_flags_t;

    // modem control requests from the core, active high
    typedef struct packed {
        logic terminalReady;
        logic requestToSend;
        logic aux1;
        logic aux2;
    } updsi_modem_ctrl_t;

    // modem control pads, active low
    typedef struct packed {
        logic terminalReadyOutN;
        logic requestToSendOutN;
        logic auxOut1N;
        logic auxOut2N;
    } updsi_modem_out_t;
endpackage : updsi_pkg

/* core/updsi_fifo.sv */
`timescale 1ns/10ps
module updsi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady,
    output logic [$clog2(DEPTH):0] level
);
    import updsi_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [AW:0] count, next_count;
    logic full, empty, next_full, next_empty;
    logic push, pop;

    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr];
    assign level = count;
    assign push = inValid && !full;
    assign pop = outReady && !empty;

    // pointer and fill bookkeeping; flags are registered for clean outputs
    always_comb begin
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_count = count;
        if (push) begin
            next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
        end
        if (pop) begin
            next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
        next_full = (next_count == (AW + 1)'(DEPTH));
        next_empty = (next_count == '0);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            full <= 1'b0;
            empty <= 1'b1;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
            full <= next_full;
            empty <= next_empty;
        end
    end

    // storage entries; data needs no reset, only the flags guard it
    for (genvar i = 0; i < DEPTH; i++) begin : gEntry
        always_ff @(posedge core_clk) begin
            if (push && wrPtr == AW'(i)) begin
                mem[i] <= inData;
            end
        end
    end
endmodule : updsi_fifo

/* core/updsi_top.sv */
// Function
// R1: tx clear drops both tx dma requests
// R2: rx clear drops both rx dma requests
// R3: controller clears on last burst item
// R4: shared scan enable, per-domain scan chains
// R5: modem status inputs active low, readable
// R6: infrared input idles high, low is zero
// R7: serial output marks high during reset
// R8: infrared output idles low, pulses on zero
// R9: modem outputs active low, reset to zero
// R10: resets assert async, release synchronously; the core takes nrst straight into its flops, with no release synchronizer
// R11: dma request outputs are active high
// R12: requests return after clear when condition holds
`timescale 1ns/10ps
module updsi_top #(
    parameter int TICK_DIV = updsi_pkg::TICK_DIV_DEFAULT,
    parameter int DEPTH = updsi_pkg::FIFO_DEPTH,
    parameter int BURST = updsi_pkg::BURST_LEVEL
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic irEnable,
    input wire logic [updsi_pkg::DATA_W-1:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic [updsi_pkg::DATA_W-1:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    output logic rxOverrun,
    input wire logic txDmaRequestClear,
    input wire logic rxDmaRequestClear,
    output updsi_pkg::updsi_dma_req_t dmaReq,
    input wire updsi_pkg::updsi_modem_in_t modemIn,
    output updsi_pkg::updsi_modem_flags_t modemFlags,
    input wire updsi_pkg::updsi_modem_ctrl_t modemCtrl,
    output updsi_pkg::updsi_modem_out_t modemOut,
    input wire logic serialRxIn,
    input wire logic infraredRxIn,
    output logic serialTxOut,
    output logic infraredTxOutN,
    input wire logic scanShiftEnable,
    input wire logic scanInBusDomain,
    input wire logic scanInRefDomain,
    output logic scanOutBusDomain,
    output logic scanOutRefDomain
);
    import updsi_pkg::*;

    localparam int LW = $clog2(DEPTH) + 1;
    localparam int DW = $clog2(TICK_DIV + 1);

    typedef enum logic {TX_IDLE, TX_SHIFT} updsi_tx_state_t;
    typedef enum logic {RX_IDLE, RX_BITS} updsi_rx_state_t;

    // baud divider: one-cycle tick at sixteen times the bit rate
    logic [DW-1:0] divCnt, next_divCnt;
    logic tick, next_tick;

    always_comb begin
        next_divCnt = divCnt + 1'b1;
        next_tick = 1'b0;
        if (divCnt == DW'(TICK_DIV - 1)) begin
            next_divCnt = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            divCnt <= '0;
            tick <= 1'b0;
        end else begin
            divCnt <= next_divCnt;
            tick <= next_tick;
        end
    end

    // fifos on both data paths
    logic txFifoValid, txFifoPop;
    logic [DATA_W-1:0] txFifoData;
    logic [LW-1:0] txLevel, rxLevel;
    logic rxPush, rxFifoReady, rxFifoValid, rxFifoPop;
    logic [DATA_W-1:0] rxWord, rxFifoData;
    logic txInReady;

    updsi_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) txFifo (
        .core_clk(core_clk),
        .nrst(nrst),
        // only a write seen with txReady high is taken
        .inValid(txValid && txReady),
        .inData(txData),
        .inReady(txInReady),
        .outValid(txFifoValid),
        .outData(txFifoData),
        .outReady(txFifoPop),
        .level(txLevel)
    );

    updsi_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) rxFifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .inValid(rxPush),
        .inData(rxWord),
        .inReady(rxFifoReady),
        .outValid(rxFifoValid),
        .outData(rxFifoData),
        .outReady(rxFifoPop),
        .level(rxLevel)
    );

    // transmitter: 10-bit frame, lsb first, sixteen ticks per bit
    updsi_tx_state_t txState, next_txState;
    logic [9:0] txShift, next_txShift;
    logic [3:0] txBit, next_txBit, txPhase, next_txPhase;
    logic next_serialTxOut, next_infraredTxOutN;

    // frames start on a tick so the start bit gets full-length ticks
    assign txFifoPop = (txState == TX_IDLE) && tick;

    always_comb begin
        next_txState = txState;
        next_txShift = txShift;
        next_txBit = txBit;
        next_txPhase = txPhase;
        case (txState)
            TX_IDLE: begin
                if (txFifoValid && tick) begin
                    next_txShift = {1'b1, txFifoData, 1'b0};
                    next_txBit = '0;
                    next_txPhase = '0;
                    next_txState = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (tick) begin
                    next_txPhase = txPhase + 1'b1;
                    if (txPhase == PHASE_LAST) begin
                        next_txShift = {1'b1, txShift[9:1]};
                        next_txBit = txBit + 1'b1;
                        if (txBit == FRAME_LAST_BIT) begin
                            next_txState = TX_IDLE;
                        end
                    end
                end
            end
            default: next_txState = TX_IDLE;
        endcase
        next_serialTxOut = (txState == TX_SHIFT) ? txShift[0] : 1'b1;
        // infrared pulse only for a zero bit, first ticks of the bit
        next_infraredTxOutN = IR_OUT_IDLE; // [R8]
        if (irEnable && txState == TX_SHIFT && !txShift[0]
                && txPhase < IR_PULSE_TICKS) begin
            next_infraredTxOutN = 1'b1; // [R8]
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            txState <= TX_IDLE;
            txShift <= '1;
            txBit <= '0;
            txPhase <= '0;
            serialTxOut <= TXD_RESET; // [R7]
            infraredTxOutN <= IR_OUT_IDLE; // [R8]
        end else begin
            txState <= next_txState;
            txShift <= next_txShift;
            txBit <= next_txBit;
            txPhase <= next_txPhase;
            serialTxOut <= next_serialTxOut;
            infraredTxOutN <= next_infraredTxOutN;
        end
    end

    // receiver; infrared pulses are short, so a bit counts as zero
    // if any low sample was seen, while the plain line uses mid-bit
    updsi_rx_state_t rxState, next_rxState;
    logic [3:0] rxBit, next_rxBit, rxPhase, next_rxPhase;
    logic [DATA_W-1:0] rxShift, next_rxShift, next_rxWord;
    logic rxMid, next_rxMid, rxSeenZero, next_rxSeenZero;
    logic next_rxPush, next_rxOverrun, rxLine, bitVal;

    assign rxLine = irEnable ? infraredRxIn : serialRxIn; // [R6]

    always_comb begin
        next_rxState = rxState;
        next_rxBit = rxBit;
        next_rxPhase = rxPhase;
        next_rxShift = rxShift;
        next_rxMid = rxMid;
        next_rxSeenZero = rxSeenZero;
        next_rxWord = rxWord;
        next_rxPush = 1'b0;
        next_rxOverrun = 1'b0;
        bitVal = irEnable ? !(rxSeenZero || !rxLine) : rxMid; // [R6]
        case (rxState)
            RX_IDLE: begin
                if (tick && !rxLine) begin
                    next_rxState = RX_BITS;
                    next_rxBit = '0;
                    next_rxPhase = 4'h1;
                    next_rxSeenZero = 1'b1;
                    next_rxMid = 1'b0;
                end
            end
            RX_BITS: begin
                if (tick) begin
                    next_rxPhase = rxPhase + 1'b1;
                    next_rxSeenZero = rxSeenZero || !rxLine;
                    if (rxPhase == PHASE_MID) begin
                        next_rxMid = rxLine;
                    end
                    if (rxPhase == PHASE_LAST) begin
                        next_rxBit = rxBit + 1'b1;
                        next_rxSeenZero = 1'b0;
                        if (rxBit == '0 && bitVal) begin
                            next_rxState = RX_IDLE; // false start
                        end else if (rxBit == STOP_BIT_INDEX) begin
                            next_rxState = RX_IDLE;
                            // framing errors are dropped silently
                            if (bitVal && rxFifoReady) begin
                                next_rxPush = 1'b1;
                                next_rxWord = rxShift;
                            end else if (bitVal) begin
                                next_rxOverrun = 1'b1;
                            end
                        end else if (rxBit != '0) begin
                            next_rxShift = {bitVal, rxShift[DATA_W-1:1]};
                        end
                    end
                end
            end
            default: next_rxState = RX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rxState <= RX_IDLE;
            rxBit <= '0;
            rxPhase <= '0;
            rxShift <= '0;
            rxMid <= 1'b1;
            rxSeenZero <= 1'b0;
            rxWord <= '0;
            rxPush <= 1'b0;
            rxOverrun <= 1'b0;
        end else begin
            rxState <= next_rxState;
            rxBit <= next_rxBit;
            rxPhase <= next_rxPhase;
            rxShift <= next_rxShift;
            rxMid <= next_rxMid;
            rxSeenZero <= next_rxSeenZero;
            rxWord <= next_rxWord;
            rxPush <= next_rxPush;
            rxOverrun <= next_rxOverrun;
        end
    end

    // output stage so the user-side read port is registered
    logic [DATA_W-1:0] next_rxData;
    logic next_rxValid;

    assign rxFifoPop = rxFifoValid && (!rxValid || rxReady);

    always_comb begin
        next_rxData = rxData;
        next_rxValid = rxValid && !rxReady;
        if (rxFifoPop) begin
            next_rxData = rxFifoData;
            next_rxValid = 1'b1;
        end
    end

    // dma requests, pads, flags and scan; all registered
    updsi_dma_req_t next_dmaReq;
    updsi_modem_flags_t next_modemFlags;
    updsi_modem_out_t next_modemOut;
    logic next_txReady;

    always_comb begin
        // a clear held by the controller keeps requests low; once it
        // drops they rise again as soon as the level allows
        next_dmaReq.txDmaSingleRequest = !txDmaRequestClear
            && txLevel < LW'(DEPTH); // [R1] [R11] [R12]
        next_dmaReq.txDmaBurstRequest = !txDmaRequestClear
            && txLevel <= LW'(DEPTH - BURST); // [R1] [R11] [R12]
        next_dmaReq.rxDmaSingleRequest = !rxDmaRequestClear
            && rxLevel != '0; // [R2] [R11] [R12]
        next_dmaReq.rxDmaBurstRequest = !rxDmaRequestClear
            && rxLevel >= LW'(BURST); // [R2] [R11] [R12]
        next_txReady = txInReady && !(txValid && txLevel == LW'(DEPTH - 1));
        next_modemFlags.clearToSend = !modemIn.clearToSendInN; // [R5]
        next_modemFlags.carrierDetect = !modemIn.carrierDetectInN; // [R5]
        next_modemFlags.setReady = !modemIn.setReadyInN; // [R5]
        next_modemFlags.ringIndicator = !modemIn.ringIndicatorInN; // [R5]
        next_modemOut.terminalReadyOutN = !modemCtrl.terminalReady; // [R9]
        next_modemOut.requestToSendOutN = !modemCtrl.requestToSend; // [R9]
        next_modemOut.auxOut1N = !modemCtrl.aux1; // [R9]
        next_modemOut.auxOut2N = !modemCtrl.aux2; // [R9]
    end

    // scan hooks stand in for inserted chains; one enable, two chains
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rxData <= '0;
            rxValid <= 1'b0;
            txReady <= 1'b0;
            dmaReq <= '0;
            modemFlags <= '0;
            modemOut <= {4{MODEM_OUT_RESET}}; // [R9]
            scanOutBusDomain <= 1'b0;
            scanOutRefDomain <= 1'b0;
        end else begin
            rxData <= next_rxData;
            rxValid <= next_rxValid;
            txReady <= next_txReady;
            dmaReq <= next_dmaReq;
            modemFlags <= next_modemFlags;
            modemOut <= next_modemOut;
            scanOutBusDomain <= scanShiftEnable && scanInBusDomain; // [R4]
            scanOutRefDomain <= scanShiftEnable && scanInRefDomain; // [R4]
        end
    end
endmodule : updsi_top

/* verif/updsi_dma_model.sv */
`timescale 1ns/10ps
// dma controller stand-in: bursts into tx, single-item reads from rx
module updsi_dma_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic slow,
    input wire logic flood,
    input wire logic [updsi_pkg::DATA_W-1:0] srcByte,
    input wire updsi_pkg::updsi_dma_req_t dmaReq,
    input wire logic txReady,
    input wire logic rxValid,
    output logic [updsi_pkg::DATA_W-1:0] txData,
    output logic txValid,
    output logic txDmaRequestClear,
    output logic rxReady,
    output logic rxDmaRequestClear,
    output logic noteValid,
    output logic [updsi_pkg::DATA_W-1:0] noteByte,
    output logic busy
);
    import updsi_pkg::*;
    logic [4:0] left;
    logic go;
    // slow mode stalls at random, as a loaded controller would
    assign go = !slow || srcByte[2:0] == 3'h0;
    assign busy = txValid || left != 5'h00;
    // tx: item held until taken, clear rides with the last item
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            txValid <= 1'b0;
            txDmaRequestClear <= 1'b0;
            txData <= 8'h00;
            left <= 5'h00;
            noteValid <= 1'b0;
            noteByte <= 8'h00;
        end else begin
            noteValid <= txValid && txReady;
            noteByte <= txData;
            if (txValid && txReady) begin
                txValid <= 1'b0;
                txDmaRequestClear <= 1'b0;
            end else if (!txValid && left != 5'h00 && go) begin
                txValid <= 1'b1;
                txData <= srcByte;
                txDmaRequestClear <= left == 5'h01;
                left <= left - 5'h01;
            end else if (!txValid && left == 5'h00 && enable &&
                         (dmaReq.txDmaBurstRequest || flood)) begin
                // flood ignores the request to push the fifo full
                left <= flood ? 5'h14 : 5'(BURST_LEVEL);
            end
        end
    end
    // rx: every read is a one-item transfer, so clear goes with it
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rxReady <= 1'b0;
            rxDmaRequestClear <= 1'b0;
        end else if (rxReady && rxValid) begin
            rxReady <= 1'b0;
            rxDmaRequestClear <= 1'b0;
        end else if (!rxReady && rxValid && go) begin
            rxReady <= 1'b1;
            rxDmaRequestClear <= 1'b1;
        end
    end
endmodule : updsi_dma_model

/* verif/updsi_top_properties.sv */
`timescale 1ns/10ps
module updsi_top_properties (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic irEnable,
    input wire logic txReady,
    input wire logic txDmaRequestClear,
    input wire logic rxDmaRequestClear,
    input wire updsi_pkg::updsi_dma_req_t dmaReq,
    input wire updsi_pkg::updsi_modem_in_t modemIn,
    input wire updsi_pkg::updsi_modem_flags_t modemFlags,
    input wire updsi_pkg::updsi_modem_ctrl_t modemCtrl,
    input wire updsi_pkg::updsi_modem_out_t modemOut,
    input wire logic serialTxOut,
    input wire logic infraredTxOutN,
    input wire logic scanShiftEnable,
    input wire logic scanInBusDomain,
    input wire logic scanInRefDomain,
    input wire logic scanOutBusDomain,
    input wire logic scanOutRefDomain
);
    import updsi_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // dma request handshake and serial mark out of reset
    txclr_drop_a: assert property (txDmaRequestClear |=>
        !dmaReq.txDmaSingleRequest && !dmaReq.txDmaBurstRequest)
        else $error("tx request stayed up under clear");
    rxclr_drop_a: assert property (rxDmaRequestClear |=>
        !dmaReq.rxDmaSingleRequest && !dmaReq.rxDmaBurstRequest)
        else $error("rx request stayed up under clear");
    req_return_a: assert property ($fell(txDmaRequestClear) && txReady
        |-> ##[0:2] dmaReq.txDmaSingleRequest)
        else $error("tx single request did not return");
    dma_active_a: assert property ($rose(nrst) |=>
        dmaReq.txDmaSingleRequest && dmaReq.txDmaBurstRequest)
        else $error("empty tx fifo not requested high");
    txd_mark_a: assert property ($rose(nrst) |-> serialTxOut)
        else $error("serial output not marking out of reset");
    // pad polarity and scan chains, one register stage
    flags_track_a: assert property ($past(nrst) |->
        modemFlags == ~$past(modemIn))
        else $error("modem flags not inverted pads");
    modem_out_a: assert property ($past(nrst) |->
        modemOut == ~$past(modemCtrl))
        else $error("modem outputs not active low");
    scan_bus_a: assert property ($past(nrst) |-> scanOutBusDomain ==
        $past(scanShiftEnable && scanInBusDomain))
        else $error("bus domain scan chain wrong");
    scan_ref_a: assert property ($past(nrst) |-> scanOutRefDomain ==
        $past(scanShiftEnable && scanInRefDomain))
        else $error("ref domain scan chain wrong");
    ir_idle_a: assert property (!irEnable && $past(!irEnable)
        |-> !infraredTxOutN)
        else $error("infrared output not idle low");
    // three ticks of two cycles; holds only for the bench divider
    ir_pulse_a: assert property ($rose(infraredTxOutN) |->
        infraredTxOutN[*6] ##1 !infraredTxOutN)
        else $error("infrared pulse length wrong");
endmodule : updsi_top_properties

bind updsi_top updsi_top_properties u_updsi_top_properties (
    .core_clk(core_clk), .nrst(nrst), .irEnable(irEnable),
    .txReady(txReady), .txDmaRequestClear(txDmaRequestClear),
    .rxDmaRequestClear(rxDmaRequestClear), .dmaReq(dmaReq),
    .modemIn(modemIn), .modemFlags(modemFlags), .modemCtrl(modemCtrl),
    .modemOut(modemOut), .serialTxOut(serialTxOut),
    .infraredTxOutN(infraredTxOutN), .scanShiftEnable(scanShiftEnable),
    .scanInBusDomain(scanInBusDomain), .scanInRefDomain(scanInRefDomain),
    .scanOutBusDomain(scanOutBusDomain), .scanOutRefDomain(scanOutRefDomain)
);

/* verif/updsi_top_tb.sv */
`timescale 1ns/10ps
module updsi_top_tb;
    import updsi_pkg::*;
    localparam int TICKS = 2; // short bit time keeps the run brief
    localparam int LIMIT = 90000;
    logic core_clk, nrst, irEnable, enable, slow, flood, sawFull;
    logic scanShiftEnable, scanInBusDomain, scanInRefDomain;
    logic txValid, txReady, rxValid, rxReady, rxOverrun, busy, noteValid;
    logic txClr, rxClr, serialTxOut, infraredTxOutN;
    logic scanOutBusDomain, scanOutRefDomain;
    logic [7:0] txData, rxData, srcByte, noteByte;
    logic [7:0] expQ[$];
    updsi_dma_req_t dmaReq;
    updsi_modem_in_t modemIn;
    updsi_modem_flags_t modemFlags;
    updsi_modem_ctrl_t modemCtrl;
    updsi_modem_out_t modemOut;
    int seed, cycles, rxCount, miscompares, checks_done;
    logic [31:0] rnd;

    updsi_top #(.TICK_DIV(TICKS)) u_updsi_top (.core_clk(core_clk),
        .nrst(nrst), .irEnable(irEnable), .txData(txData),
        .txValid(txValid), .txReady(txReady), .rxData(rxData),
        .rxValid(rxValid), .rxReady(rxReady), .rxOverrun(rxOverrun),
        .txDmaRequestClear(txClr), .rxDmaRequestClear(rxClr),
        .dmaReq(dmaReq), .modemIn(modemIn), .modemFlags(modemFlags),
        .modemCtrl(modemCtrl), .modemOut(modemOut),
        .serialRxIn(serialTxOut), .infraredRxIn(~infraredTxOutN),
        .serialTxOut(serialTxOut), .infraredTxOutN(infraredTxOutN),
        .scanShiftEnable(scanShiftEnable), .scanInBusDomain(scanInBusDomain),
        .scanInRefDomain(scanInRefDomain),
        .scanOutBusDomain(scanOutBusDomain),
        .scanOutRefDomain(scanOutRefDomain));
    updsi_dma_model u_updsi_dma_model (.core_clk(core_clk), .nrst(nrst),
        .enable(enable), .slow(slow), .flood(flood), .srcByte(srcByte),
        .dmaReq(dmaReq), .txReady(txReady), .rxValid(rxValid),
        .txData(txData), .txValid(txValid), .txDmaRequestClear(txClr),
        .rxReady(rxReady), .rxDmaRequestClear(rxClr),
        .noteValid(noteValid), .noteByte(noteByte), .busy(busy));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // pad and scan inputs wander at random every cycle
    always @(posedge core_clk) begin
        rnd = $random(seed);
        modemIn <= rnd[3:0];
        modemCtrl <= rnd[7:4];
        scanShiftEnable <= rnd[8];
        scanInBusDomain <= rnd[9];
        scanInRefDomain <= rnd[10];
        srcByte <= rnd[23:16];
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            stop_test();
        end
    end

    // notes from the driver, oldest compared when a byte comes back
    always @(posedge core_clk) begin
        if (noteValid) expQ.push_back(noteByte);
        if (flood && txReady === 1'b0) sawFull = 1'b1;
        if (nrst && rxOverrun !== 1'b0) check("rx overrun", 8'h01, 8'h00);
        if (nrst && rxValid && rxReady) begin
            rxCount++;
            if (expQ.size() == 0) check("rx spurious", 8'h01, 8'h00);
            else check("rx byte", rxData, expQ.pop_front());
        end
    end

    task automatic check_reset;
        nrst <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        check("serial tx in reset", 8'(serialTxOut), 8'h01);
        check("infrared tx in reset", 8'(infraredTxOutN), 8'h00);
        check("modem out in reset", 8'(modemOut), 8'h00);
        check("dma req in reset", 8'(dmaReq), 8'h00);
        @(posedge core_clk);
        nrst <= 1'b1;
    endtask : check_reset

    // stop new bursts and wait until every sent byte came back
    task automatic drain;
        int waited;
        enable <= 1'b0;
        waited = 0;
        while ((expQ.size() != 0 || busy) && waited < 20000) begin
            @(posedge core_clk);
            waited++;
        end
        repeat (40) @(posedge core_clk);
    endtask : drain

    task automatic phase(input logic ir, input logic sl, input logic fl,
                         input int n);
        int target;
        int waited;
        drain();
        irEnable <= ir; // line idle, so switching mode is safe
        slow <= sl;
        flood <= fl;
        enable <= 1'b1;
        target = rxCount + n;
        waited = 0;
        while (rxCount < target && waited < 30000) begin
            @(posedge core_clk);
            waited++;
        end
        check("bytes looped", 8'(rxCount >= target), 8'h01);
    endtask : phase

    initial begin
        nrst = 1'b0;
        {irEnable, enable, slow, flood, sawFull} = 5'h00;
        {scanShiftEnable, scanInBusDomain, scanInRefDomain} = 3'h0;
        modemIn = 4'hF;
        modemCtrl = 4'h0;
        srcByte = 8'h00;
        seed = 32'ha711;
        {cycles, rxCount, miscompares, checks_done} = '0;
        check_reset();
        phase(1'b0, 1'b0, 1'b0, 12);
        phase(1'b0, 1'b1, 1'b0, 8);
        phase(1'b0, 1'b1, 1'b1, 24);
        check("tx fifo refused", 8'(sawFull), 8'h01);
        phase(1'b1, 1'b0, 1'b0, 8); // infrared round trip
        phase(1'b1, 1'b1, 1'b0, 4);
        drain();
        check_reset(); // second reset in mid-run
        phase(1'b0, 1'b0, 1'b0, 4);
        drain();
        stop_test();
    end
endmodule : updsi_top_tb
